// File: verilog/rsh_ref_switch.sv
//Behaviour
// - Bit 4 of reference control picks manual (0) or automatic (1) switchover.
// - Stay bit clear: return to primary once primary status is good again.
// - Stay bit set: remain on secondary after switchover, never return alone.
// - Without automatic switchover, bit 2 powers the secondary input on or off.
// - Without automatic switchover, bit 1 powers the primary input on or off.
// - Bit 0 selects single-ended (0) or differential (1) reference mode.
// - Single-ended inputs and automatic switchover work only in single-ended mode.
// - Holdover control bit 4 set blocks status register readback.
// - Comparator enabled in internal holdover: it tells whether PLL was locked.
// - Comparator disabled: internal holdover treats the lock pin as high.
// - Holdover works only when holdover bits 2 and 0 are both set.
// - External control bit hands holdover to the hold pin, internal mode off.
// - External control bit clear: internal circuit governs holdover entry and exit.
// - Outside internal holdover, comparator result is routed to the monitor pin.
// - External control set: holdover follows the external hold pin.
// - Manual mode bit 5 takes the selection from register bit 6 or the pin.
module rsh_ref_switch
    import rsh_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    // Clock and reset.
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // AHB-Lite slave.
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // Reference monitors and pins.
    input  wire logic              primary_ref_good,
    input  wire logic              secondary_ref_good,
    input  wire logic              ref_select_pin,
    input  wire logic              hold_pin,
    input  wire logic              lock_detect_pin,
    input  wire logic              pll_locked,
    // Reference and holdover controls.
    output logic                   primary_reference_input_power,
    output logic                   secondary_reference_input_power,
    output logic                   secondary_selected,
    output logic                   differential_mode,
    output logic                   switchover_deglitch_off,
    output logic                   holdover_active,
    output logic                   reference_monitor_pin
);

    // The word index comes from address bits 9 to 2, so a narrower bus cannot carry it.
    if (ADDR_W < 10)
    begin
        $error("ADDR_W must be at least 10");
    end

    ////////////////////////////////////////////////////////////////////////////////
    logic [RSH_PIN_COUNT-1:0] pin_meta;
    logic [RSH_PIN_COUNT-1:0] pin_sync;
    logic [7:0]               ref_ctrl;
    logic [7:0]               hold_ctrl;
    logic                     wr_pend;
    logic [7:0]               wr_idx;
    rsh_sel_e                 sel_state;
    rsh_sel_e                 next_sel_state;
    logic                     next_holdover;
    logic                     next_monitor;

    // Monitor flags and pins come from other domains, so each passes two flops.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_meta <= '0;
            pin_sync <= '0;
        end
        else
        begin
            pin_meta <= {pll_locked, lock_detect_pin, hold_pin,
                         ref_select_pin, secondary_ref_good, primary_ref_good};
            pin_sync <= pin_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
        word_index = a[9:2];
    endfunction

    wire logic addr_ok  = hsel && hready && (htrans == RSH_HTRANS_NONSEQ);
    wire logic aligned  = (haddr[1:0] == 2'h0) && (haddr[ADDR_W-1:2] < (1 << 8));

    wire logic [7:0] status_byte =
        (8'h01 << RSH_ST_LOCKED_BIT)   & {8{pin_sync[RSH_PIN_LOCKED]}}   |
        (8'h01 << RSH_ST_PRI_GOOD_BIT) & {8{pin_sync[RSH_PIN_PRI_GOOD]}} |
        (8'h01 << RSH_ST_SEC_GOOD_BIT) & {8{pin_sync[RSH_PIN_SEC_GOOD]}} |
        (8'h01 << RSH_ST_SEC_SEL_BIT)  & {8{secondary_selected}}         |
        (8'h01 << RSH_ST_HOLD_BIT)     & {8{holdover_active}}            |
        (8'h01 << RSH_ST_LDCMP_BIT)    & {8{pin_sync[RSH_PIN_LDCMP]}};

    // A read right behind a write to the same register sees the new value.
    function automatic logic [7:0] read_byte(input logic [7:0] idx);
        logic [7:0] r;
        logic [7:0] h;
        r = (wr_pend && wr_idx == RSH_IDX_REF_CTRL) ? hwdata[7:0] : ref_ctrl;
        h = (wr_pend && wr_idx == RSH_IDX_HOLD_CTRL) ? hwdata[7:0] : hold_ctrl;
        case (idx)
            RSH_IDX_REF_CTRL:  read_byte = r;
            RSH_IDX_HOLD_CTRL: read_byte = h;
            RSH_IDX_STATUS:    read_byte = h[RSH_HOLD_STAT_DIS_BIT] ? 8'h00 : status_byte;
            default:           read_byte = 8'h00;
        endcase
    endfunction

    // Zero wait states, always OKAY; unmapped reads give zero, writes are dropped.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
            wr_pend   <= 1'b0;
            wr_idx    <= 8'h00;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend   <= addr_ok && hwrite && aligned;
            wr_idx    <= word_index(haddr);
            if (addr_ok && !hwrite)
            begin
                hrdata <= {24'h00_0000, aligned ? read_byte(word_index(haddr)) : 8'h00};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ref_ctrl  <= RSH_REF_CTRL_RST;
            hold_ctrl <= RSH_HOLD_CTRL_RST;
        end
        else if (wr_pend)
        begin
            if (wr_idx == RSH_IDX_REF_CTRL)
            begin
                ref_ctrl <= hwdata[7:0];
            end
            if (wr_idx == RSH_IDX_HOLD_CTRL)
            begin
                hold_ctrl <= hwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    wire logic diff_mode   = ref_ctrl[RSH_REF_DIFF_BIT];
    wire logic auto_mode   = ref_ctrl[RSH_REF_AUTO_BIT] && !diff_mode;
    wire logic stay_sec    = ref_ctrl[RSH_REF_STAY_SEC_BIT];
    wire logic pri_good    = pin_sync[RSH_PIN_PRI_GOOD];
    wire logic sec_good    = pin_sync[RSH_PIN_SEC_GOOD];
    wire logic manual_sec  = ref_ctrl[RSH_REF_USE_PIN_BIT] ? pin_sync[RSH_PIN_REF_SEL]
                                                           : ref_ctrl[RSH_REF_SEL_SEC_BIT];
    wire logic hold_en     = hold_ctrl[RSH_HOLD_EN2_BIT] && hold_ctrl[RSH_HOLD_EN0_BIT];
    wire logic ext_hold    = hold_ctrl[RSH_HOLD_EXT_BIT];
    wire logic int_hold    = hold_en && !ext_hold;
    wire logic cmp_en      = hold_ctrl[RSH_HOLD_LDCMP_BIT];
    wire logic was_locked  = cmp_en ? pin_sync[RSH_PIN_LDCMP] : 1'b1;

    // Selection state; the differential input always rides the primary path.
    always_comb
    begin
        next_sel_state = sel_state;
        case (sel_state)
            RSH_SEL_PRIMARY:
            begin
                if (diff_mode)
                begin
                    next_sel_state = RSH_SEL_PRIMARY;
                end
                else if (auto_mode)
                begin
                    if (!pri_good && sec_good)
                    begin
                        next_sel_state = RSH_SEL_SECONDARY;
                    end
                end
                else if (manual_sec)
                begin
                    next_sel_state = RSH_SEL_SECONDARY;
                end
            end
            RSH_SEL_SECONDARY:
            begin
                if (diff_mode)
                begin
                    next_sel_state = RSH_SEL_PRIMARY;
                end
                else if (auto_mode)
                begin
                    if (pri_good && !stay_sec)
                    begin
                        next_sel_state = RSH_SEL_PRIMARY;
                    end
                end
                else if (!manual_sec)
                begin
                    next_sel_state = RSH_SEL_PRIMARY;
                end
            end
            default:
            begin
                next_sel_state = RSH_SEL_PRIMARY;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sel_state <= RSH_SEL_PRIMARY;
        end
        else
        begin
            sel_state <= next_sel_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    wire logic sel_good = diff_mode ? pri_good
                        : ((sel_state == RSH_SEL_SECONDARY) ? sec_good : pri_good);

    // Internal holdover is entered only if the loop was locked before the loss, when the comparator is enabled; with it disabled the lock is assumed.
    always_comb
    begin
        next_holdover = 1'b0;
        if (hold_en && ext_hold)
        begin
            next_holdover = pin_sync[RSH_PIN_HOLD];
        end
        else if (int_hold)
        begin
            if (holdover_active)
            begin
                next_holdover = !sel_good;
            end
            else
            begin
                next_holdover = !sel_good && was_locked;
            end
        end
    end

    // The monitor pin shows the comparator only while internal holdover is not using it.
    always_comb
    begin
        next_monitor = cmp_en && !int_hold && pin_sync[RSH_PIN_LDCMP];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            holdover_active       <= 1'b0;
            reference_monitor_pin <= 1'b0;
        end
        else
        begin
            holdover_active       <= next_holdover;
            reference_monitor_pin <= next_monitor;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Automatic switchover needs both inputs awake to judge their status.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            primary_reference_input_power   <= 1'b0;
            secondary_reference_input_power <= 1'b0;
            secondary_selected              <= 1'b0;
            differential_mode               <= 1'b0;
            switchover_deglitch_off         <= 1'b0;
        end
        else
        begin
            primary_reference_input_power   <= !diff_mode
                && (auto_mode || ref_ctrl[RSH_REF_PRI_PWR_BIT]);
            secondary_reference_input_power <= !diff_mode
                && (auto_mode || ref_ctrl[RSH_REF_SEC_PWR_BIT]);
            secondary_selected              <= (next_sel_state == RSH_SEL_SECONDARY);
            differential_mode               <= diff_mode;
            switchover_deglitch_off         <= ref_ctrl[RSH_REF_NO_DEGL_BIT];
        end
    end

endmodule

// File: verilog/rsh_pkg.sv
package rsh_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] RSH_IDX_REF_CTRL  = 8'h1c;
    localparam logic [7:0] RSH_IDX_HOLD_CTRL = 8'h1d;
    localparam logic [7:0] RSH_IDX_STATUS    = 8'h1f;

    localparam logic [7:0] RSH_REF_CTRL_RST  = 8'h00;
    localparam logic [7:0] RSH_HOLD_CTRL_RST = 8'h00;

    // Reference input control fields.
    localparam int RSH_REF_DIFF_BIT      = 0;
    localparam int RSH_REF_PRI_PWR_BIT   = 1;
    localparam int RSH_REF_SEC_PWR_BIT   = 2;
    localparam int RSH_REF_STAY_SEC_BIT  = 3;
    localparam int RSH_REF_AUTO_BIT      = 4;
    localparam int RSH_REF_USE_PIN_BIT   = 5;
    localparam int RSH_REF_SEL_SEC_BIT   = 6;
    localparam int RSH_REF_NO_DEGL_BIT   = 7;

    // Holdover and lock control fields.
    localparam int RSH_HOLD_EN0_BIT      = 0;
    localparam int RSH_HOLD_EXT_BIT      = 1;
    localparam int RSH_HOLD_EN2_BIT      = 2;
    localparam int RSH_HOLD_LDCMP_BIT    = 3;
    localparam int RSH_HOLD_STAT_DIS_BIT = 4;

    // Status fields.
    localparam int RSH_ST_LOCKED_BIT     = 0;
    localparam int RSH_ST_PRI_GOOD_BIT   = 1;
    localparam int RSH_ST_SEC_GOOD_BIT   = 2;
    localparam int RSH_ST_SEC_SEL_BIT    = 4;
    localparam int RSH_ST_HOLD_BIT       = 5;
    localparam int RSH_ST_LDCMP_BIT      = 6;

    // Synchronised pin vector positions.
    localparam int RSH_PIN_PRI_GOOD      = 0;
    localparam int RSH_PIN_SEC_GOOD      = 1;
    localparam int RSH_PIN_REF_SEL       = 2;
    localparam int RSH_PIN_HOLD          = 3;
    localparam int RSH_PIN_LDCMP         = 4;
    localparam int RSH_PIN_LOCKED        = 5;
    localparam int RSH_PIN_COUNT         = 6;

    localparam logic [1:0] RSH_HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0]
    {
        RSH_SEL_PRIMARY   = 2'h1,
        RSH_SEL_SECONDARY = 2'h2
    } rsh_sel_e;

endpackage

// File: bench/rsh_ref_switch_checker.sv
module rsh_ref_switch_checker
    import rsh_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    // Clock, reset and bus.
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic [31:0]       hwdata,
    input wire logic              hready,
    input wire logic [31:0]       hrdata,
    input wire logic              hreadyout,
    // Pins and controls.
    input wire logic              ref_select_pin,
    input wire logic              hold_pin,
    input wire logic              lock_detect_pin,
    input wire logic              primary_reference_input_power,
    input wire logic              secondary_reference_input_power,
    input wire logic              secondary_selected,
    input wire logic              differential_mode,
    input wire logic              holdover_active,
    input wire logic              reference_monitor_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [ADDR_W-1:0] A_REF = ADDR_W'({RSH_IDX_REF_CTRL, 2'h0});
    localparam logic [ADDR_W-1:0] A_HLD = ADDR_W'({RSH_IDX_HOLD_CTRL, 2'h0});
    localparam logic [ADDR_W-1:0] A_ST  = ADDR_W'({RSH_IDX_STATUS, 2'h0});
    logic              ph_wr;
    logic [ADDR_W-1:0] ph_a;
    logic [7:0]        sh_ref;
    logic [7:0]        sh_hld;
    logic              take;
    logic              aut;
    logic              pin_mode;
    logic              stay_mode;
    logic              hen;
    logic              hext;
    logic              hint;
    logic              cmp;

    ////////////////////////////////////////////////////////////////////////////
    // Shadow copies of the registers, rebuilt from the bus alone.
    assign take      = hsel && hready && htrans == RSH_HTRANS_NONSEQ;
    assign aut       = sh_ref[RSH_REF_AUTO_BIT] && !sh_ref[RSH_REF_DIFF_BIT];
    assign pin_mode  = !sh_ref[RSH_REF_AUTO_BIT] && !sh_ref[RSH_REF_DIFF_BIT] && sh_ref[5];
    assign stay_mode = aut && sh_ref[RSH_REF_STAY_SEC_BIT];
    assign hen       = sh_hld[RSH_HOLD_EN0_BIT] && sh_hld[RSH_HOLD_EN2_BIT];
    assign hext      = hen && sh_hld[RSH_HOLD_EXT_BIT];
    assign hint      = hen && !sh_hld[RSH_HOLD_EXT_BIT];
    assign cmp       = sh_hld[RSH_HOLD_LDCMP_BIT];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_wr <= 1'b0;
            ph_a  <= '0;
        end
        else if (hready)
        begin
            ph_wr <= take && hwrite;
            ph_a  <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            sh_ref <= RSH_REF_CTRL_RST;
        else if (ph_wr && hready && ph_a == A_REF)
            sh_ref <= hwdata[7:0];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            sh_hld <= RSH_HOLD_CTRL_RST;
        else if (ph_wr && hready && ph_a == A_HLD)
            sh_hld <= hwdata[7:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs trail the registers by one edge and the pins by three.
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_READY: assert property (hreadyout) else $error("bus stalled");
    AST_DIFF: assert property (differential_mode == $past(sh_ref[0]))
        else $error("differential mode differs from its bit");
    AST_PRI_PWR: assert property (primary_reference_input_power ==
        $past(aut || (!sh_ref[0] && sh_ref[1]))) else $error("primary power wrong");
    AST_SEC_PWR: assert property (secondary_reference_input_power ==
        $past(aut || (!sh_ref[0] && sh_ref[2]))) else $error("secondary power wrong");
    AST_MAN_SEL: assert property (!$past(aut) && !$past(sh_ref[5]) |->
        secondary_selected == $past(sh_ref[6] && !sh_ref[0])) else $error("manual select wrong");
    AST_PIN_SEL: assert property ($past(pin_mode) && $past(pin_mode, 4) |->
        secondary_selected == $past(ref_select_pin, 3)) else $error("pin select wrong");
    AST_STAY: assert property ($past(stay_mode) && $past(secondary_selected) |->
        secondary_selected) else $error("left the secondary input");
    AST_HOLD_OFF: assert property (!$past(hen) |-> !holdover_active)
        else $error("holdover while disabled");
    AST_EXT_HOLD: assert property ($past(hext) && $past(hext, 4) |->
        holdover_active == $past(hold_pin, 3)) else $error("holdover not following pin");
    AST_INT_ENTRY: assert property ($rose(holdover_active) && $past(hint) && $past(cmp)
        |-> $past(lock_detect_pin, 3)) else $error("holdover entered without lock");
    AST_REFERENCE_MONITOR_PIN: assert property (reference_monitor_pin |-> $past(cmp) && !$past(hint)
        && $past(lock_detect_pin, 3)) else $error("monitor pin wrong");
    AST_STAT_GATE: assert property (take && !hwrite && haddr == A_ST
        && sh_hld[RSH_HOLD_STAT_DIS_BIT] |=> hrdata == 32'h0) else $error("status not gated");
endmodule

bind rsh_ref_switch rsh_ref_switch_checker #(.ADDR_W(ADDR_W)) rsh_ref_switch_checker_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .ref_select_pin(ref_select_pin), .hold_pin(hold_pin),
    .lock_detect_pin(lock_detect_pin),
    .primary_reference_input_power(primary_reference_input_power),
    .secondary_reference_input_power(secondary_reference_input_power),
    .secondary_selected(secondary_selected), .differential_mode(differential_mode),
    .holdover_active(holdover_active), .reference_monitor_pin(reference_monitor_pin));

// File: bench/rsh_ref_source.sv
module rsh_ref_source
    import rsh_pkg::*;
(
    // Clock and requested levels.
    input  wire logic       hclk,
    input  wire logic [5:0] want,
    // Pins towards the device.
    output logic            primary_ref_good,
    output logic            secondary_ref_good,
    output logic            ref_select_pin,
    output logic            hold_pin,
    output logic            lock_detect_pin,
    output logic            pll_locked
);
    timeunit 1ns;
    timeprecision 1ps;

    // Pins are registered on each rising edge, so they take the requested levels one clock later.
    always_ff @(posedge hclk)
    begin
        primary_ref_good   <= want[RSH_PIN_PRI_GOOD];
        secondary_ref_good <= want[RSH_PIN_SEC_GOOD];
        ref_select_pin     <= want[RSH_PIN_REF_SEL];
        hold_pin           <= want[RSH_PIN_HOLD];
        lock_detect_pin    <= want[RSH_PIN_LDCMP];
        pll_locked         <= want[RSH_PIN_LOCKED];
    end
endmodule

// File: bench/rsh_ref_switch_bench.sv
module rsh_ref_switch_bench import rsh_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] A_REF = 12'h070;
    localparam logic [11:0] A_HLD = 12'h074;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata;
    logic [5:0]  pins;
    logic        pgood, sgood, rsel, hpin, ldp, lck;
    logic        ppwr, spwr, sel, diff, degl, hact, mon;
    logic [6:0]  outs;
    int          failures;
    int          check_count;

    assign outs = {degl, mon, hact, sel, diff, spwr, ppwr};

    rsh_ref_switch #(.ADDR_W(12)) rsh_ref_switch_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .primary_ref_good(pgood), .secondary_ref_good(sgood), .ref_select_pin(rsel),
        .hold_pin(hpin), .lock_detect_pin(ldp), .pll_locked(lck),
        .primary_reference_input_power(ppwr), .secondary_reference_input_power(spwr),
        .secondary_selected(sel), .differential_mode(diff),
        .switchover_deglitch_off(degl), .holdover_active(hact), .reference_monitor_pin(mon));

    rsh_ref_source rsh_ref_source_i (
        .hclk(hclk), .want(pins), .primary_ref_good(pgood), .secondary_ref_good(sgood),
        .ref_select_pin(rsel), .hold_pin(hpin), .lock_detect_pin(ldp), .pll_locked(lck));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            failures++;
        end
    endtask

    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= RSH_HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        ahb(1'b0, a, 32'h0, d);
        chk(d, e);
        chk({31'h0, hresp}, 32'h0);
    endtask

    // Move the pins, write a register, let both settle, then check outputs and readback.
    task automatic step(input logic [11:0] a, input logic [7:0] d, input logic [5:0] p,
                        input logic [6:0] e);
        logic [31:0] unused;
        pins <= p;
        ahb(1'b1, a, {24'h0, d}, unused);
        repeat (6) @(posedge hclk);
        chk(32'(outs), 32'(e));
        rd_chk(a, {24'h0, d});
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    initial
    begin
        repeat (20000) @(posedge hclk);
        failures++;
        close_out();
    end

    initial
    begin
        {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        hsize = 3'h2;
        pins = 6'h23;
        hresetn = 1'b0;
        failures = 0;
        check_count = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(32'(outs), 32'h0);
        rd_chk(A_REF, 32'h0);
        rd_chk(A_HLD, 32'h0);
        rd_chk(12'h100, 32'h0);
        rd_chk(12'h07c, 32'h07);
        $display("reset and map test done");
        step(A_REF, 8'h06, 6'h03, 7'h03);
        step(A_REF, 8'h04, 6'h03, 7'h02);
        step(A_REF, 8'h42, 6'h03, 7'h09);
        step(A_REF, 8'h22, 6'h03, 7'h01);
        step(A_REF, 8'h22, 6'h07, 7'h09);
        step(A_REF, 8'h47, 6'h07, 7'h04);
        step(A_REF, 8'h57, 6'h02, 7'h04);
        $display("manual and differential test done");
        step(A_REF, 8'h10, 6'h03, 7'h03);
        step(A_REF, 8'h10, 6'h02, 7'h0b);
        step(A_REF, 8'h10, 6'h03, 7'h03);
        step(A_REF, 8'h18, 6'h02, 7'h0b);
        step(A_REF, 8'h18, 6'h03, 7'h0b);
        step(A_REF, 8'h82, 6'h03, 7'h41);
        step(A_REF, 8'h02, 6'h03, 7'h01);
        $display("switchover test done");
        step(A_HLD, 8'h07, 6'h0b, 7'h11);
        step(A_HLD, 8'h07, 6'h03, 7'h01);
        step(A_HLD, 8'h03, 6'h0b, 7'h01);
        step(A_HLD, 8'h06, 6'h0b, 7'h01);
        step(A_HLD, 8'h0d, 6'h02, 7'h01);
        step(A_HLD, 8'h0d, 6'h12, 7'h11);
        step(A_HLD, 8'h0d, 6'h13, 7'h01);
        step(A_HLD, 8'h05, 6'h02, 7'h11);
        step(A_HLD, 8'h05, 6'h03, 7'h01);
        $display("holdover test done");
        step(A_HLD, 8'h08, 6'h13, 7'h21);
        step(A_HLD, 8'h0d, 6'h13, 7'h01);
        step(A_HLD, 8'h10, 6'h23, 7'h01);
        rd_chk(12'h07c, 32'h0);
        step(A_HLD, 8'h00, 6'h23, 7'h01);
        rd_chk(12'h07c, 32'h07);
        $display("monitor and status test done");
        close_out();
    end
endmodule
